/* File: hw/afc_host.sv */
// Host controller that drives a parallel NOR flash over its chip, output and write enables.
// Assumes DQ is resolved from DQ_OUT/DQ_OE outside, and the ready/busy pin is asynchronous.
`timescale 1ns/100ps
// Functional notes
// - Host starts with two unlock writes
// - Then EBh and 27h to address zero
// - Range count 0Ah/15h, option FFFEh
// - Expected CRC as four words, low first
// - Start/stop follow; stop must exceed start
// - Confirm 29h, then poll until ready
// - Whole-array count 04h/09h, option FFFFh
module afc_host #(
  parameter int ADDR_W = 23
) (
  input  wire logic              CLOCK,
  input  wire logic              RST_N,
  input  wire logic              BYTE_MODE,
  input  wire logic              CMD_VALID,
  input  afc_pkg::afc_op_e       CMD_OP,
  input  wire logic [31:0]       CMD_ADDR,
  input  wire logic [31:0]       CMD_STOP,
  input  wire logic [63:0]       CMD_CRC,
  output logic                   CMD_READY,
  output logic                   DONE,
  output logic                   REFUSED,
  output logic [15:0]            RDATA,
  output logic                   CHECK_ERR,
  output logic                   CE_N,
  output logic                   OE_N,
  output logic                   WE_N,
  output logic                   BYTE_N,
  output logic [ADDR_W-1:0]      ADDR,
  input  wire logic [15:0]       DQ_IN,
  output logic [15:0]            DQ_OUT,
  output logic [15:0]            DQ_OE,
  input  wire logic              READY_BUSY_OUT
);
  import afc_pkg::*;

  typedef enum logic [2:0] {ST_IDLE, ST_SETUP, ST_STROBE, ST_HOLD, ST_RDWAIT, ST_WAITBUSY, ST_POLL} afc_state_e;

  afc_state_e  state;
  afc_op_e     op_q;
  logic        bm;
  logic        status_rd;
  logic [5:0]  k;
  logic [5:0]  nsteps;
  logic [7:0]  cnt;
  logic [31:0] addr_q;
  logic [31:0] stop_q;
  logic [63:0] crc_q;
  logic [15:0] dq_s1;
  logic [15:0] dq_s2;
  logic        rb_s1;
  logic        rb_s2;
  logic [48:0] cur;
  logic        cmd_refuse;

  // Payload word j of a CRC sequence, at word offset j
  function automatic logic [15:0] payload_word(input logic [3:0] j);
    case (j)
      4'h0: payload_word = (op_q == OP_CRC_RANGE) ? OPT_RANGE : OPT_WHOLE;
      4'h1: payload_word = crc_q[15:0];
      4'h2: payload_word = crc_q[31:16];
      4'h3: payload_word = crc_q[47:32];
      4'h4: payload_word = crc_q[63:48];
      4'h5: payload_word = addr_q[15:0];
      4'h6: payload_word = addr_q[31:16];
      4'h8: payload_word = stop_q[15:0];
      4'h9: payload_word = stop_q[31:16];
      default: payload_word = RSVD_WORD;
    endcase
  endfunction : payload_word

  // Bus cycle number k of the current sequence as {read, address, data}
  function automatic logic [48:0] item(input logic [5:0] kk);
    logic        rd;
    logic [31:0] a;
    logic [15:0] d;
    logic [5:0]  p;
    logic [15:0] w;
    rd = 1'b0;
    a = CMD_ADDR_ZERO;
    d = RSVD_WORD;
    p = kk - PREFIX_STEPS;
    w = payload_word(bm ? p[4:1] : p[3:0]);
    if (status_rd) begin
      rd = 1'b1;
    end else if (op_q == OP_READ) begin
      rd = 1'b1;
      a = addr_q;
    end else if (op_q == OP_RESET) begin
      d = RESET_CODE;
    end else if (kk == 6'h00) begin
      a = bm ? UNLOCK1_BYTE : UNLOCK1_WORD;
      d = UNLOCK1_DATA;
    end else if (kk == 6'h01) begin
      a = bm ? UNLOCK2_BYTE : UNLOCK2_WORD;
      d = UNLOCK2_DATA;
    end else if (op_q == OP_AUTOSEL) begin
      a = bm ? UNLOCK1_BYTE : UNLOCK1_WORD;
      d = AUTOSEL_CODE;
    end else if (kk == 6'h02) begin
      d = EXT_FUNC_CODE;
    end else if (kk == 6'h03) begin
      d = CRC_SUBOP_CODE;
    end else if (kk == 6'h04) begin
      if (op_q == OP_CRC_RANGE) d = bm ? CNT_RANGE_BYTE : CNT_RANGE_WORD;
      else d = bm ? CNT_WHOLE_BYTE : CNT_WHOLE_WORD;
    end else if (kk == nsteps - 6'h01) begin
      d = CONFIRM_CODE;
    end else begin
      // Byte mode sends low byte then high byte of each word
      a = {26'h0, p};
      d = !bm ? w : (p[0] ? {8'h00, w[15:8]} : {8'h00, w[7:0]});
    end
    return {rd, a, d};
  endfunction : item

  assign cur = item(k);
  // Auto-select needs a ready device; a suspended device reports ready
  assign cmd_refuse = ((CMD_OP == OP_AUTOSEL) && !rb_s2)
                    || ((CMD_OP == OP_CRC_RANGE) && (CMD_STOP <= CMD_ADDR));

  // Pin synchronisers: first stage feeds only the second
  always_ff @(posedge CLOCK) begin
    if (!RST_N) begin
      dq_s1 <= 16'h0000;
      dq_s2 <= 16'h0000;
      rb_s1 <= 1'b0;
      rb_s2 <= 1'b0;
    end else begin
      dq_s1 <= DQ_IN;
      dq_s2 <= dq_s1;
      rb_s1 <= READY_BUSY_OUT;
      rb_s2 <= rb_s1;
    end
  end

  // Sequencer and bus pins
  always_ff @(posedge CLOCK) begin
    if (!RST_N) begin
      state <= ST_IDLE;
      op_q <= OP_READ;
      bm <= 1'b0;
      status_rd <= 1'b0;
      k <= 6'h00;
      nsteps <= STEPS_SINGLE;
      cnt <= 8'h00;
      addr_q <= 32'h0000_0000;
      stop_q <= 32'h0000_0000;
      crc_q <= 64'h0;
      CMD_READY <= 1'b0;
      CE_N <= 1'b1;
      OE_N <= 1'b1;
      WE_N <= 1'b1;
      BYTE_N <= 1'b1;
      ADDR <= '0;
      DQ_OUT <= 16'h0000;
      DQ_OE <= OE_NONE;
    end else begin
      case (state)
        ST_IDLE: begin
          CMD_READY <= 1'b1;
          BYTE_N <= !BYTE_MODE;
          if (CMD_VALID && CMD_READY && !cmd_refuse) begin
            CMD_READY <= 1'b0;
            op_q <= CMD_OP;
            bm <= BYTE_MODE;
            addr_q <= CMD_ADDR;
            stop_q <= CMD_STOP;
            crc_q <= CMD_CRC;
            status_rd <= 1'b0;
            k <= 6'h00;
            if (CMD_OP == OP_AUTOSEL) nsteps <= STEPS_AUTOSEL;
            else if (CMD_OP == OP_CRC_RANGE) nsteps <= PREFIX_STEPS + STEPS_SINGLE + (WORDS_RANGE << BYTE_MODE);
            else if (CMD_OP == OP_CRC_WHOLE) nsteps <= PREFIX_STEPS + STEPS_SINGLE + (WORDS_WHOLE << BYTE_MODE);
            else nsteps <= STEPS_SINGLE;
            state <= ST_SETUP;
          end
        end
        ST_SETUP: begin
          // Address and data settle before the strobe falls
          CE_N <= 1'b0;
          ADDR <= bm ? cur[16+ADDR_W:17] : cur[15+ADDR_W:16];
          DQ_OUT <= {(bm ? cur[16] : cur[TOP_DQ_BIT]), cur[14:0]};
          if (cur[48]) begin
            OE_N <= 1'b0;
            DQ_OE <= bm ? OE_BYTE_READ : OE_NONE;
            cnt <= RD_CYC;
            state <= ST_RDWAIT;
          end else begin
            DQ_OE <= bm ? OE_BYTE_WRITE : OE_WORD_WRITE;
            cnt <= WP_CYC;
            state <= ST_STROBE;
          end
        end
        ST_STROBE: begin
          WE_N <= 1'b0;
          if (cnt == 8'h01) state <= ST_HOLD;
          cnt <= cnt - 8'h01;
        end
        ST_HOLD: begin
          // Strobe rises alone; chip enable and data let go one cycle later so the flash latches clean data
          WE_N <= 1'b1;
          if (WE_N) begin
            CE_N <= 1'b1;
            DQ_OE <= OE_NONE;
            k <= k + 6'h01;
            if (k != nsteps - 6'h01) begin
              state <= ST_SETUP;
            end else if (op_q == OP_CRC_WHOLE || op_q == OP_CRC_RANGE) begin
              cnt <= BUSY_CYC;
              state <= ST_WAITBUSY;
            end else begin
              state <= ST_IDLE;
            end
          end
        end
        ST_RDWAIT: begin
          if (cnt == 8'h01) begin
            OE_N <= 1'b1;
            CE_N <= 1'b1;
            DQ_OE <= OE_NONE;
            state <= ST_IDLE;
          end
          cnt <= cnt - 8'h01;
        end
        ST_WAITBUSY: begin
          // Busy flag is not valid right after the confirm write
          if (cnt == 8'h01) state <= ST_POLL;
          cnt <= cnt - 8'h01;
        end
        ST_POLL: begin
          if (rb_s2) begin
            status_rd <= 1'b1;
            state <= ST_SETUP;
          end
        end
        default: state <= ST_IDLE;
      endcase
    end
  end

  // Results: read data, check error, done and refusal pulses
  always_ff @(posedge CLOCK) begin
    if (!RST_N) begin
      DONE <= 1'b0;
      REFUSED <= 1'b0;
      RDATA <= 16'h0000;
      CHECK_ERR <= 1'b0;
    end else begin
      DONE <= 1'b0;
      REFUSED <= 1'b0;
      if (state == ST_IDLE && CMD_VALID && CMD_READY && cmd_refuse) begin
        REFUSED <= 1'b1;
        DONE <= 1'b1;
      end
      if (state == ST_HOLD && WE_N && k == nsteps - 6'h01 && op_q != OP_CRC_WHOLE && op_q != OP_CRC_RANGE) begin
        DONE <= 1'b1;
      end
      if (state == ST_RDWAIT && cnt == 8'h01) begin
        RDATA <= dq_s2;
        DONE <= 1'b1;
        if (status_rd) CHECK_ERR <= dq_s2[CHECK_ERROR_BIT];
      end
    end
  end

  default clocking cb @(posedge CLOCK); endclocking
  default disable iff (!RST_N);

  wire crc_op = (op_q == OP_CRC_WHOLE) || (op_q == OP_CRC_RANGE);
  wire strobing = (state == ST_STROBE) && crc_op && !status_rd;

  a_unlock_first: assert property (strobing && k == 6'h00 |-> DQ_OUT[7:0] == UNLOCK1_DATA[7:0]
    && (bm ? ADDR == UNLOCK1_BYTE[ADDR_W:1] : ADDR == UNLOCK1_WORD[ADDR_W-1:0]))
    else $error("first unlock write wrong");
  a_unlock_second: assert property (strobing && k == 6'h01 |-> DQ_OUT[7:0] == UNLOCK2_DATA[7:0])
    else $error("second unlock write wrong");
  a_ext_codes: assert property (strobing && k == 6'h02 |-> DQ_OUT[7:0] == EXT_FUNC_CODE[7:0] && ADDR == '0
    ##[1:8] (strobing && k == 6'h03 && DQ_OUT[7:0] == CRC_SUBOP_CODE[7:0]))
    else $error("extended function codes out of order");
  a_range_count: assert property (strobing && k == 6'h04 && op_q == OP_CRC_RANGE
    |-> DQ_OUT[7:0] == (bm ? CNT_RANGE_BYTE[7:0] : CNT_RANGE_WORD[7:0]))
    else $error("range data count wrong");
  a_whole_option: assert property (strobing && k == 6'h05 && op_q == OP_CRC_WHOLE && !bm
    |-> DQ_OUT == OPT_WHOLE && ADDR == '0)
    else $error("whole-array option word wrong");
  a_crc_words: assert property (strobing && !bm && k == 6'h06 |-> DQ_OUT == crc_q[15:0] && ADDR == 1)
    else $error("first expected CRC word wrong");
  a_range_refuse: assert property (state == ST_IDLE && CMD_VALID && CMD_READY && CMD_OP == OP_CRC_RANGE
    && CMD_STOP <= CMD_ADDR |=> REFUSED && DONE && state == ST_IDLE)
    else $error("empty range not refused");
  a_confirm_poll: assert property (strobing && k == nsteps - 6'h01 |-> DQ_OUT[7:0] == CONFIRM_CODE[7:0]
    ##[1:4] state == ST_WAITBUSY)
    else $error("confirm not followed by polling");

  c_crc_range: cover property (state == ST_POLL && op_q == OP_CRC_RANGE ##[1:1000] DONE);
  c_check_fail: cover property ($rose(CHECK_ERR));
  c_autosel_refused: cover property (state == ST_IDLE && CMD_VALID && CMD_READY && CMD_OP == OP_AUTOSEL ##1 REFUSED);
endmodule : afc_host

/* File: hw/afc_pkg.sv */
// Constants for the host-side controller of a parallel NOR flash.
// Assumes a 10 MHz system clock and a flash that takes bus cycles on its control pins.
package afc_pkg;
  // Host-level operations
  typedef enum logic [2:0] {OP_READ, OP_RESET, OP_AUTOSEL, OP_CRC_WHOLE, OP_CRC_RANGE} afc_op_e;

  localparam int CLK_FREQ_MHZ = 10;
  localparam int T_WRITE_PULSE_NS = 50;   // Write strobe low time
  localparam int T_READ_ACCESS_NS = 70;   // Output-enable to valid data
  localparam int T_BUSY_DELAY_NS = 500;   // Confirm to busy-flag valid
  localparam int SYNC_STAGES = 2;

  // Least time rounded up to whole cycles, at least one
  function automatic int afc_cycles(input int ns);
    int c;
    c = (ns * CLK_FREQ_MHZ + 999) / 1000;
    return (c < 1) ? 1 : c;
  endfunction : afc_cycles

  localparam logic [7:0] WP_CYC = 8'(afc_cycles(T_WRITE_PULSE_NS));
  localparam logic [7:0] RD_CYC = 8'(afc_cycles(T_READ_ACCESS_NS) + SYNC_STAGES);
  localparam logic [7:0] BUSY_CYC = 8'(afc_cycles(T_BUSY_DELAY_NS));

  // Command addresses and codes
  localparam logic [31:0] UNLOCK1_WORD = 32'h0000_0555;
  localparam logic [31:0] UNLOCK2_WORD = 32'h0000_02AA;
  localparam logic [31:0] UNLOCK1_BYTE = 32'h0000_0AAA;
  localparam logic [31:0] UNLOCK2_BYTE = 32'h0000_0555;
  localparam logic [31:0] CMD_ADDR_ZERO = 32'h0000_0000;
  localparam logic [15:0] UNLOCK1_DATA = 16'h00AA;
  localparam logic [15:0] UNLOCK2_DATA = 16'h0055;
  localparam logic [15:0] AUTOSEL_CODE = 16'h0090;
  localparam logic [15:0] RESET_CODE = 16'h00F0;
  localparam logic [15:0] EXT_FUNC_CODE = 16'h00EB;
  localparam logic [15:0] CRC_SUBOP_CODE = 16'h0027;
  localparam logic [15:0] CONFIRM_CODE = 16'h0029;
  localparam logic [15:0] CNT_RANGE_WORD = 16'h000A;
  localparam logic [15:0] CNT_RANGE_BYTE = 16'h0015;
  localparam logic [15:0] CNT_WHOLE_WORD = 16'h0004;
  localparam logic [15:0] CNT_WHOLE_BYTE = 16'h0009;
  localparam logic [15:0] OPT_RANGE = 16'hFFFE;
  localparam logic [15:0] OPT_WHOLE = 16'hFFFF;
  localparam logic [15:0] RSVD_WORD = 16'h0000;

  // Sequence shape: unlock x2, EB, 27, count, payload, confirm
  localparam logic [5:0] PREFIX_STEPS = 6'h05;
  localparam logic [5:0] WORDS_RANGE = 6'h0B;
  localparam logic [5:0] WORDS_WHOLE = 6'h05;
  localparam logic [5:0] STEPS_AUTOSEL = 6'h03;
  localparam logic [5:0] STEPS_SINGLE = 6'h01;

  // Pin usage
  localparam int CHECK_ERROR_BIT = 5;
  localparam int TOP_DQ_BIT = 15;
  localparam logic [15:0] OE_WORD_WRITE = 16'hFFFF;
  localparam logic [15:0] OE_BYTE_WRITE = 16'h80FF;
  localparam logic [15:0] OE_BYTE_READ = 16'h8000;
  localparam logic [15:0] OE_NONE = 16'h0000;
endpackage : afc_pkg

/* File: tb/afc_flash_model.sv */
// Behavioural parallel NOR flash seen only at its pins; every write goes into a log.
// Assumes the bench resolves DQ from both drivers and feeds it back here.
`timescale 1ns/100ps
module afc_flash_model #(
  parameter logic [15:0] MAKER_ID  = 16'h00C3,  // Identity values are arbitrary
  parameter logic [15:0] DEV1_ID   = 16'h1111,
  parameter logic [15:0] DEV2_ID   = 16'h2222,
  parameter logic [15:0] DEV3_ID   = 16'h3333,
  parameter logic        PRELOCK   = 1'b0,
  parameter logic        HIGH_LOCK = 1'b0,
  parameter int          MEM_BYTES = 2048   // Array span that a whole check covers
) (
  input  wire logic        ce_n,
  input  wire logic        oe_n,
  input  wire logic        we_n,
  input  wire logic        byte_n,
  input  wire logic [22:0] addr,
  input  wire logic [15:0] dq,
  input  wire logic        hold_busy,
  input  wire logic        bad_array,
  output logic [15:0]      dq_dev,
  output logic             ready_busy_out
);
  logic [39:0] wlog[$];  // Address and data of each write
  logic        autosel = 1'b0;
  logic        status  = 1'b0;
  logic        busy    = 1'b0;
  logic        chk_err = 1'b0;   // Outcome of the last check
  logic        cnt_next = 1'b0;  // Next write carries the data count
  logic [7:0]  prev    = 8'h00;  // Low byte of the previous write
  logic [7:0]  pay[23];          // Payload bytes of a check, option first
  int          left    = 0;      // Payload writes still owed
  int          got     = 0;      // Payload bytes taken so far
  logic [31:0] lo;
  logic [31:0] hi;
  logic [63:0] exp_crc;
  logic [15:0] rd_val;
  localparam logic [63:0] CRC_POLY = 64'h42F0_E1EB_A9EA_3693;  // Generator, x^64 term implied

  // Serial CRC over bytes [lo, hi) of the array pattern, each byte LSB first, from zero
  function automatic logic [63:0] crc64_span(input int lo_b, input int hi_b, input logic corrupt);
    logic [63:0] crc;
    logic [15:0] word;
    logic [7:0]  b;
    logic        fb;
    crc = 64'h0;
    for (int a = lo_b; a < hi_b; a++) begin
      word = 16'(a >>> 1) ^ 16'h5A5A;
      b = a[0] ? word[15:8] : word[7:0];
      if (corrupt && a == lo_b) b[0] = ~b[0];
      for (int i = 0; i < 8; i++) begin
        fb = crc[63] ^ b[i];
        crc = {crc[62:0], 1'b0} ^ (fb ? CRC_POLY : 64'h0);
      end
    end
    return crc;
  endfunction : crc64_span
  logic [15:0] last    = 16'h0000;
  wire  [23:0] wa      = byte_n ? {1'b0, addr} : {addr, dq[15]};

  // Command decode on the write strobe's rising edge; check payload is data, never a command
  always @(posedge we_n) if (!ce_n) begin
    wlog.push_back({wa, byte_n ? dq : {8'h00, dq[7:0]}});
    if (left > 0) begin
      if (got < 22) begin
        pay[got]     = dq[7:0];
        pay[got + 1] = dq[15:8];
      end
      got  = got + (byte_n ? 2 : 1);
      left = left - 1;
    end else if (cnt_next) begin
      cnt_next = 1'b0;
      left     = int'(dq[7:0]) + 1;  // Count is N-1
      got      = 0;
    end else begin
      if (dq[7:0] == 8'h27 && prev == 8'hEB) cnt_next = 1'b1;
      if (dq[7:0] == 8'hAA) status = 1'b0;
      if (dq[7:0] == 8'h90 && ready_busy_out) autosel = 1'b1;
      if (dq[7:0] == 8'hF0) begin
        autosel = 1'b0;
        status  = 1'b0;
      end
      if (dq[7:0] == 8'h29) begin
        lo      = {pay[13], pay[12], pay[11], pay[10]};
        hi      = {pay[19], pay[18], pay[17], pay[16]};
        exp_crc = {pay[9], pay[8], pay[7], pay[6], pay[5], pay[4], pay[3], pay[2]};
        if ({pay[1], pay[0]} == 16'hFFFF) chk_err = (crc64_span(0, MEM_BYTES, bad_array) != exp_crc);
        else if (hi > lo) chk_err = (crc64_span(int'(lo), int'(hi), bad_array) != exp_crc);
        else chk_err = 1'b0;
        status = 1'b1;
        busy   = 1'b1;
        busy  <= #2000 1'b0;  // Check runs for 20 cycles
      end
    end
    prev = dq[7:0];
  end

  // Read data: status after a check, signature tables in auto-select, else a pattern
  always_comb begin
    rd_val = addr[15:0] ^ 16'h5A5A;
    if (status) rd_val = {8'h00, 2'b10, chk_err, 5'h00};
    else if (autosel && addr[15:2] == 14'h0 && addr[1:0] == 2'h2) rd_val = {15'h0, addr[16]};
    else if (autosel && addr[22:2] == 21'h0 && addr[1:0] == 2'h3)
      rd_val = {8'h00, PRELOCK, 2'b00, HIGH_LOCK, 4'h9};
    else if (autosel && addr[22:4] == 19'h0 && addr[3:0] == 4'h0) rd_val = MAKER_ID;
    else if (autosel && addr[22:4] == 19'h0 && addr[3:0] == 4'h1) rd_val = DEV1_ID;
    else if (autosel && addr[22:4] == 19'h0 && addr[3:0] == 4'hE) rd_val = DEV2_ID;
    else if (autosel && addr[22:4] == 19'h0 && addr[3:0] == 4'hF) rd_val = DEV3_ID;
  end

  // Released bus shows the inverse of the last value, not a stale copy
  always @(posedge oe_n) last <= rd_val;
  assign dq_dev = (!ce_n && !oe_n) ? rd_val : ~last;
  assign ready_busy_out = ~(busy | hold_busy);
endmodule : afc_flash_model

/* File: tb/tb.sv */
// Self-checking bench for the flash host controller against a behavioural flash.
// Assumes the controller and package as delivered; DQ is resolved here from both drivers by DQ_OE alone.
`timescale 1ns/100ps
module tb;
  import afc_pkg::*;
  logic CLOCK = 1'b0, RST_N = 1'b0, BYTE_MODE = 1'b0, CMD_VALID = 1'b0;
  logic hold_busy = 1'b0, bad_array = 1'b0, refused;
  afc_op_e CMD_OP = OP_READ;
  logic [31:0] CMD_ADDR = 32'h0, CMD_STOP = 32'h0;
  logic [63:0] CMD_CRC = 64'h0;
  logic CMD_READY, DONE, REFUSED, CHECK_ERR, CE_N, OE_N, WE_N, BYTE_N, RB;
  logic [15:0] RDATA, DQ_OUT, DQ_OE, dq_dev;
  logic [22:0] ADDR;
  logic [39:0] exp_q[$];
  int err_count = 0, n_checks = 0;
  wire [15:0] dq_bus = (DQ_OE & DQ_OUT) | (~DQ_OE & dq_dev);  // Both drivers resolved

  always #50 CLOCK = ~CLOCK;

  afc_host i_dut (.CLOCK(CLOCK), .RST_N(RST_N), .BYTE_MODE(BYTE_MODE), .CMD_VALID(CMD_VALID),
    .CMD_OP(CMD_OP), .CMD_ADDR(CMD_ADDR), .CMD_STOP(CMD_STOP), .CMD_CRC(CMD_CRC), .CMD_READY(CMD_READY),
    .DONE(DONE), .REFUSED(REFUSED), .RDATA(RDATA), .CHECK_ERR(CHECK_ERR), .CE_N(CE_N), .OE_N(OE_N),
    .WE_N(WE_N), .BYTE_N(BYTE_N), .ADDR(ADDR), .DQ_IN(dq_bus), .DQ_OUT(DQ_OUT), .DQ_OE(DQ_OE),
    .READY_BUSY_OUT(RB));
  afc_flash_model #(.HIGH_LOCK(1'b1)) i_flash (.ce_n(CE_N), .oe_n(OE_N), .we_n(WE_N), .byte_n(BYTE_N),
    .addr(ADDR), .dq(dq_bus), .hold_busy(hold_busy), .bad_array(bad_array), .dq_dev(dq_dev),
    .ready_busy_out(RB));

  task automatic print_verdict();
    $display("checks %0d mismatches %0d", n_checks, err_count);
    if (err_count == 0 && n_checks > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask : print_verdict

  task automatic check(input logic [63:0] seen, input logic [63:0] exp);
    n_checks++;
    if (seen !== exp) begin
      err_count++;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  // One command through the request port; the bench stays just past an edge between calls
  task automatic run(input afc_op_e op, input logic [31:0] a, input logic [31:0] s, input logic [63:0] c);
    int i;
    for (i = 0; i < 50 && CMD_READY !== 1'b1; i++) begin @(posedge CLOCK); #1; end
    if (i == 50) begin
      err_count++;
      print_verdict();
    end
    @(posedge CLOCK);
    CMD_VALID <= 1'b1;
    CMD_OP <= op;
    CMD_ADDR <= a;
    CMD_STOP <= s;
    CMD_CRC <= c;
    @(posedge CLOCK);
    CMD_VALID <= 1'b0;
    #1;
    for (i = 0; i < 3000 && DONE !== 1'b1; i++) begin @(posedge CLOCK); #1; end
    if (i == 3000) begin
      err_count++;
      print_verdict();
    end
    refused = REFUSED;
  endtask : run

  task automatic ex(input logic [23:0] a, input logic [15:0] d);
    exp_q.push_back({a, d});
  endtask : ex

  // Compare the logged writes with the expected list, then empty both
  task automatic check_log();
    check(i_flash.wlog.size(), exp_q.size());
    foreach (exp_q[k]) if (k < i_flash.wlog.size()) check(i_flash.wlog[k], exp_q[k]);
    exp_q.delete();
    i_flash.wlog.delete();
  endtask : check_log

  task automatic t_autosel();
    logic [31:0] a[7] = '{32'h0, 32'h1, 32'hE, 32'hF, 32'h3, 32'h2, 32'h1_0002};
    logic [15:0] v[7] = '{i_flash.MAKER_ID, i_flash.DEV1_ID, i_flash.DEV2_ID, i_flash.DEV3_ID,
                          16'h0019, 16'h0000, 16'h0001};
    run(OP_AUTOSEL, 32'h0, 32'h0, 64'h0);
    foreach (a[k]) begin
      run(OP_READ, a[k], 32'h0, 64'h0);
      check(RDATA, v[k]);
    end
    run(OP_RESET, 32'h0, 32'h0, 64'h0);
    run(OP_READ, 32'h1, 32'h0, 64'h0);
    check(RDATA, 16'h5A5B);
    $display("test autoselect done");
  endtask : t_autosel

  task automatic t_busy();
    @(posedge CLOCK) hold_busy <= 1'b1;
    repeat (4) @(posedge CLOCK);
    #1;
    i_flash.wlog.delete();
    run(OP_AUTOSEL, 32'h0, 32'h0, 64'h0);
    check(refused, 1'b1);
    check(i_flash.wlog.size(), 0);
    @(posedge CLOCK) hold_busy <= 1'b0;  // Suspended operation reports ready
    repeat (4) @(posedge CLOCK);
    #1;
    run(OP_AUTOSEL, 32'h0, 32'h0, 64'h0);
    check(refused, 1'b0);
    run(OP_READ, 32'h0, 32'h0, 64'h0);
    check(RDATA, i_flash.MAKER_ID);
    run(OP_RESET, 32'h0, 32'h0, 64'h0);
    $display("test busy refusal done");
  endtask : t_busy

  // The model takes the payload as data, so any CRC value may be sent
  task automatic t_crc(input logic bm, input logic whole, input logic bad);
    logic [31:0] s = 32'h0000_0100, e = 32'h0000_0400;
    logic [63:0] c;
    logic [15:0] w[11];
    // Expected CRC of the clean array; the model corrupts its array when bad is set
    c = i_flash.crc64_span(whole ? 0 : int'(s), whole ? i_flash.MEM_BYTES : int'(e), 1'b0);
    w = '{whole ? 16'hFFFF : 16'hFFFE, c[15:0], c[31:16], c[47:32], c[63:48],
          s[15:0], s[31:16], 16'h0, e[15:0], e[31:16], 16'h0};
    @(posedge CLOCK);
    BYTE_MODE <= bm;
    bad_array <= bad;
    @(posedge CLOCK);
    #1;
    i_flash.wlog.delete();
    ex(bm ? 24'hAAA : 24'h555, 16'h00AA);
    ex(bm ? 24'h555 : 24'h2AA, 16'h0055);
    ex(24'h0, 16'h00EB);
    ex(24'h0, 16'h0027);
    ex(24'h0, bm ? (whole ? 16'h0009 : 16'h0015) : (whole ? 16'h0004 : 16'h000A));
    for (int j = 0; j < (whole ? 5 : 11); j++)
      if (bm) begin
        ex(24'(2 * j), {8'h00, w[j][7:0]});
        ex(24'(2 * j + 1), {8'h00, w[j][15:8]});
      end else ex(24'(j), w[j]);
    ex(24'h0, 16'h0029);
    run(whole ? OP_CRC_WHOLE : OP_CRC_RANGE, s, e, c);
    check(refused, 1'b0);
    check_log();
    check(CHECK_ERR, bad);
    run(OP_CRC_RANGE, e, e, c);
    check(refused, 1'b1);
    check(i_flash.wlog.size(), 0);
    $display("test crc mode %0d whole %0d done", bm, whole);
  endtask : t_crc

  initial begin
    repeat (16) @(posedge CLOCK);
    RST_N <= 1'b1;
    repeat (3) @(posedge CLOCK);
    #1;
    t_autosel();
    t_busy();
    t_crc(1'b0, 1'b0, 1'b0);
    t_crc(1'b0, 1'b1, 1'b1);
    t_crc(1'b1, 1'b1, 1'b0);
    t_crc(1'b1, 1'b0, 1'b1);
    print_verdict();
  end
endmodule : tb
